// ===== rtl/spp_consts.svh
`ifndef SPP_CONSTS_SVH
`define SPP_CONSTS_SVH

// pin count and bus widths
`define SPP_NPIN        6
`define SPP_AW          8
`define SPP_DW          32

// register byte offsets
`define SPP_OFF_DIR     8'h00
`define SPP_OFF_PULL    8'h04
`define SPP_OFF_OUT     8'h08
`define SPP_OFF_IN      8'h0c
`define SPP_OFF_SET     8'h10
`define SPP_OFF_CLR     8'h14
`define SPP_OFF_CFG     8'h18
`define SPP_OFF_CHG     8'h1c

// reset values: all inputs, weak pull-up, output level low
`define SPP_RST_DIR     6'h00
`define SPP_RST_PULL    12'h555
`define SPP_RST_OUT     6'h00
`define SPP_RST_CHG     6'h00

// single-pin configuration word fields
`define SPP_CFG_IDX_LO  0
`define SPP_CFG_IDX_HI  2
`define SPP_CFG_DIR     3
`define SPP_CFG_PULL_LO 4
`define SPP_CFG_PULL_HI 5
`define SPP_CFG_LVL     6

`endif

// ===== rtl/spp_pkg.sv
`default_nettype none

package spp_pkg;

  typedef enum logic [1:0] {
    SPP_PULL_NONE   = 2'b00,
    SPP_PULL_WEAK   = 2'b01,
    SPP_PULL_STRONG = 2'b10,
    SPP_PULL_RSVD   = 2'b11
  } spp_pull_t;

endpackage

`default_nettype wire

// ===== rtl/spp_sync.sv
`default_nettype none

module spp_sync #(
  parameter int W = 1
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  // two-stage synchroniser, the first stage feeds only the second
  always_comb begin
    meta_nxt = d;
    q_nxt    = meta_r;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      meta_r <= '1;
      q_r    <= '1;
    end else begin
      meta_r <= meta_nxt;
      q_r    <= q_nxt;
    end
  end

  assign q = q_r;

endmodule

`default_nettype wire

// ===== rtl/spp_top.sv
// Our own choices: the register addresses and strobed register access.

`include "spp_consts.svh"

`default_nettype none

module spp_top (
  input  wire logic                 mclk,
  input  wire logic                 rst,
  input  wire logic [`SPP_AW-1:0]   addr,
  input  wire logic [`SPP_DW-1:0]   wr_data,
  input  wire logic                 wr_stb,
  input  wire logic                 rd_stb,
  output logic      [`SPP_DW-1:0]   rd_data,
  input  wire logic [`SPP_NPIN-1:0] spare_pin_in,
  output logic      [`SPP_NPIN-1:0] spare_pin_out,
  output logic      [`SPP_NPIN-1:0] spare_pin_oe_n,
  output logic      [`SPP_NPIN-1:0] spare_pin_weak_pu,
  output logic      [`SPP_NPIN-1:0] spare_pin_strong_pu
);

  localparam int NP = `SPP_NPIN;

  // configuration state
  logic [NP-1:0]   dir_r;
  logic [NP-1:0]   dir_nxt;
  logic [2*NP-1:0] pull_r;
  logic [2*NP-1:0] pull_nxt;
  logic [NP-1:0]   lvl_r;
  logic [NP-1:0]   lvl_nxt;
  logic [NP-1:0]   chg_r;
  logic [NP-1:0]   chg_nxt;
  logic [NP-1:0]   prev_r;
  logic [NP-1:0]   prev_nxt;

  // registered outputs
  logic [`SPP_DW-1:0] rd_data_r;
  logic [`SPP_DW-1:0] rd_data_nxt;
  logic [NP-1:0]      pin_out_r;
  logic [NP-1:0]      pin_out_nxt;
  logic [NP-1:0]      pin_oe_n_r;
  logic [NP-1:0]      pin_oe_n_nxt;
  logic [NP-1:0]      weak_r;
  logic [NP-1:0]      weak_nxt;
  logic [NP-1:0]      strong_r;
  logic [NP-1:0]      strong_nxt;

  logic [NP-1:0] pin_sync;

  // single-pin command fields
  logic [2:0] cfg_idx;
  logic       cfg_dir;
  logic [1:0] cfg_pull;
  logic       cfg_lvl;
  logic       cfg_hit;

  // pad inputs pass two flops before use
  spp_sync #(
    .W (NP)
  ) u_sync (
    .mclk (mclk),
    .rst  (rst),
    .d    (spare_pin_in),
    .q    (pin_sync)
  );

  // single-pin command decode, index above the last pin ignored
  always_comb begin
    cfg_idx  = wr_data[`SPP_CFG_IDX_HI:`SPP_CFG_IDX_LO];
    cfg_dir  = wr_data[`SPP_CFG_DIR];
    cfg_pull = wr_data[`SPP_CFG_PULL_HI:`SPP_CFG_PULL_LO];
    cfg_lvl  = wr_data[`SPP_CFG_LVL];
    cfg_hit  = 1'b0;
    if (wr_stb && addr == `SPP_OFF_CFG) begin
      cfg_hit = (cfg_idx < 3'(NP));
    end
  end

  // direction, changed only by an explicit command
  always_comb begin
    dir_nxt = dir_r;
    if (wr_stb && addr == `SPP_OFF_DIR) begin
      dir_nxt = wr_data[NP-1:0];
    end else if (cfg_hit) begin
      dir_nxt[cfg_idx] = cfg_dir;
    end
  end

  // pull-up selection, two bits per pin
  always_comb begin
    pull_nxt = pull_r;
    if (wr_stb && addr == `SPP_OFF_PULL) begin
      pull_nxt = wr_data[2*NP-1:0];
    end else if (cfg_hit) begin
      pull_nxt[2*cfg_idx +: 2] = cfg_pull;
    end
  end

  // output levels: whole word, set, clear or single pin
  always_comb begin
    lvl_nxt = lvl_r;
    if (wr_stb && addr == `SPP_OFF_OUT) begin
      lvl_nxt = wr_data[NP-1:0];
    end else if (wr_stb && addr == `SPP_OFF_SET) begin
      lvl_nxt = lvl_r | wr_data[NP-1:0];
    end else if (wr_stb && addr == `SPP_OFF_CLR) begin
      lvl_nxt = lvl_r & ~wr_data[NP-1:0];
    end else if (cfg_hit) begin
      lvl_nxt[cfg_idx] = cfg_lvl;
    end
  end

  // input change flags; a change arriving with its clear still sets it
  always_comb begin
    logic [NP-1:0] edge_seen;
    edge_seen = (pin_sync ^ prev_r) & ~dir_r;
    prev_nxt  = pin_sync;
    chg_nxt   = chg_r;
    if (wr_stb && addr == `SPP_OFF_CHG) begin
      chg_nxt = chg_r & ~wr_data[NP-1:0];
    end
    chg_nxt = chg_nxt | edge_seen;
  end

  // pin drivers and pull-up selection
  always_comb begin
    spp_pkg::spp_pull_t mode;
    mode         = spp_pkg::SPP_PULL_WEAK;
    pin_out_nxt  = lvl_nxt;
    pin_oe_n_nxt = ~dir_nxt;
    weak_nxt     = '0;
    strong_nxt   = '0;
    for (int i = 0; i < NP; i++) begin
      mode = spp_pkg::spp_pull_t'(pull_nxt[2*i +: 2]);
      if (!dir_nxt[i]) begin
        case (mode)
          spp_pkg::SPP_PULL_NONE: begin
            weak_nxt[i]   = 1'b0;
            strong_nxt[i] = 1'b0;
          end
          spp_pkg::SPP_PULL_STRONG: begin
            strong_nxt[i] = 1'b1;
          end
          default: begin
            weak_nxt[i] = 1'b1;
          end
        endcase
      end
    end
  end

  // read mux, data valid in the cycle after the strobe only
  always_comb begin
    rd_data_nxt = '0;
    if (rd_stb) begin
      if (addr == `SPP_OFF_DIR) begin
        rd_data_nxt[NP-1:0] = dir_r;
      end else if (addr == `SPP_OFF_PULL) begin
        rd_data_nxt[2*NP-1:0] = pull_r;
      end else if (addr == `SPP_OFF_OUT) begin
        rd_data_nxt[NP-1:0] = lvl_r;
      end else if (addr == `SPP_OFF_IN) begin
        rd_data_nxt[NP-1:0] = pin_sync;
      end else if (addr == `SPP_OFF_CFG) begin
        rd_data_nxt = '0;
      end else if (addr == `SPP_OFF_CHG) begin
        rd_data_nxt[NP-1:0] = chg_r;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      dir_r <= `SPP_RST_DIR;
    end else begin
      dir_r <= dir_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      pull_r <= `SPP_RST_PULL;
    end else begin
      pull_r <= pull_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      lvl_r <= `SPP_RST_OUT;
    end else begin
      lvl_r <= lvl_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      chg_r  <= `SPP_RST_CHG;
      prev_r <= '1;
    end else begin
      chg_r  <= chg_nxt;
      prev_r <= prev_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rd_data_r <= '0;
    end else begin
      rd_data_r <= rd_data_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      pin_out_r  <= `SPP_RST_OUT;
      pin_oe_n_r <= '1;
      weak_r     <= '1;
      strong_r   <= '0;
    end else begin
      pin_out_r  <= pin_out_nxt;
      pin_oe_n_r <= pin_oe_n_nxt;
      weak_r     <= weak_nxt;
      strong_r   <= strong_nxt;
    end
  end

  assign rd_data             = rd_data_r;
  assign spare_pin_out       = pin_out_r;
  assign spare_pin_oe_n      = pin_oe_n_r;
  assign spare_pin_weak_pu   = weak_r;
  assign spare_pin_strong_pu = strong_r;

endmodule

`default_nettype wire

// ===== verif/spp_pad.sv
`default_nettype none
module spp_pad (
  input  wire logic       mclk,
  input  wire logic [5:0] spare_pin_out,
  input  wire logic [5:0] spare_pin_oe_n,
  input  wire logic [5:0] spare_pin_weak_pu,
  input  wire logic [5:0] spare_pin_strong_pu,
  input  wire logic [5:0] ext_lvl,
  input  wire logic [5:0] ext_en,
  output logic      [5:0] spare_pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic tog = 1'b0;
  always @(posedge mclk) tog <= ~tog;
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (ext_en[i]) spare_pin_in[i] = ext_lvl[i];
      else if (!spare_pin_oe_n[i]) spare_pin_in[i] = spare_pin_out[i];
      else if (spare_pin_weak_pu[i] | spare_pin_strong_pu[i])
        spare_pin_in[i] = 1'b1;
      else spare_pin_in[i] = tog; // floating pin
    end
  end
endmodule
`default_nettype wire

// ===== verif/spp_top_monitor.sv
`default_nettype none
module spp_top_monitor (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wr_data,
  input wire logic        wr_stb,
  input wire logic        rd_stb,
  input wire logic [31:0] rd_data,
  input wire logic [5:0]  spare_pin_out,
  input wire logic [5:0]  spare_pin_oe_n,
  input wire logic [5:0]  spare_pin_weak_pu,
  input wire logic [5:0]  spare_pin_strong_pu
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  property p_rst; $past(rst) |-> spare_pin_oe_n == 6'h3f &&
    spare_pin_weak_pu == 6'h3f && spare_pin_strong_pu == 6'h00; endproperty
  property p_dir; $past(wr_stb) && $past(addr) == 8'h00 |->
    spare_pin_oe_n == ~$past(wr_data[5:0]); endproperty
  property p_out; $past(wr_stb) && $past(addr) == 8'h08 |->
    spare_pin_out == $past(wr_data[5:0]); endproperty
  property p_drv; (~spare_pin_oe_n &
    (spare_pin_weak_pu | spare_pin_strong_pu)) == 6'h00; endproperty
  property p_nop; $past(wr_stb) && $past(addr) == 8'h04 &&
    $past(wr_data[11:0]) == 12'h000 |->
    (spare_pin_weak_pu | spare_pin_strong_pu) == 6'h00; endproperty
  property p_hold; !$past(wr_stb) |-> $stable(spare_pin_oe_n) &&
    $stable(spare_pin_out) && $stable(spare_pin_weak_pu) &&
    $stable(spare_pin_strong_pu); endproperty
  property p_map; $past(rd_stb) && $past(addr) > 8'h1c |->
    rd_data == 32'h0; endproperty
  a_rst: assert property (p_rst) else $error("pins not reset");
  a_dir: assert property (p_dir) else $error("bad direction");
  a_out: assert property (p_out) else $error("bad level");
  a_drv: assert property (p_drv) else $error("pull on output");
  a_nop: assert property (p_nop) else $error("pull not off");
  a_hold: assert property (p_hold) else $error("pin changed");
  a_map: assert property (p_map) else $error("unmapped read");
  c_dir: cover property ($past(wr_stb) && $past(addr) == 8'h00);
  c_rd: cover property (rd_stb);
  c_rst: cover property ($fell(rst));
  c_cfg: cover property (wr_stb && addr == 8'h18);
endmodule
bind spp_top spp_top_monitor i_mon (.mclk, .rst, .addr, .wr_data, .wr_stb,
  .rd_stb, .rd_data, .spare_pin_out, .spare_pin_oe_n, .spare_pin_weak_pu,
  .spare_pin_strong_pu);
`default_nettype wire

// ===== verif/tb.sv
`default_nettype none
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin \
  num_errors++; $display("MISMATCH %s exp %h got %h", n, e, s); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, rst = 1, wr_stb = 0, rd_stb = 0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wr_data = 32'h0, rd_data;
  logic [5:0] spare_pin_in, spare_pin_out, spare_pin_oe_n;
  logic [5:0] spare_pin_weak_pu, spare_pin_strong_pu;
  logic [5:0] ext_lvl = 6'h00, ext_en = 6'h00;
  int num_errors = 0, checked = 0, cyc = 0;
  always #12.5 mclk = ~mclk;
  spp_top i_dut (.mclk, .rst, .addr, .wr_data, .wr_stb, .rd_stb, .rd_data,
    .spare_pin_in, .spare_pin_out, .spare_pin_oe_n, .spare_pin_weak_pu,
    .spare_pin_strong_pu);
  spp_pad i_pad (.mclk, .spare_pin_out, .spare_pin_oe_n, .spare_pin_weak_pu,
    .spare_pin_strong_pu, .ext_lvl, .ext_en, .spare_pin_in);
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a; wr_data <= d; wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
    #1;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    addr <= a; rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    #1 `CHK("rd_data", e, rd_data)
  endtask
  task pins(input logic [5:0] oe, wk, st);
    `CHK("oe_n", oe, spare_pin_oe_n)
    `CHK("weak_pu", wk, spare_pin_weak_pu)
    `CHK("strong_pu", st, spare_pin_strong_pu)
  endtask
  task results;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 2000) begin
      num_errors++;
      results;
    end
  end
  initial begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    #1 pins(6'h3f, 6'h3f, 6'h00);
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h555);
    rd(8'h0c, 32'h3f);
    wr(8'h08, 32'h2a);
    wr(8'h00, 32'h0f);
    pins(6'h30, 6'h30, 6'h00);
    `CHK("out", 6'h2a, spare_pin_out)
    ext_en <= 6'h30;
    ext_lvl <= 6'h10;
    repeat (4) @(posedge mclk);
    rd(8'h0c, 32'h1a);
    wr(8'h04, 32'h255);
    pins(6'h30, 6'h00, 6'h10);
    wr(8'h0c, 32'h0);
    rd(8'h20, 32'h0);
    @(posedge mclk);
    #1 `CHK("rd_idle", 32'h0, rd_data)
    repeat (10) @(posedge mclk);
    #1 `CHK("out", 6'h2a, spare_pin_out)
    rd(8'h1c, 32'h20);
    wr(8'h1c, 32'h3f);
    rd(8'h1c, 32'h0);
    ext_en <= 6'h10;
    repeat (4) @(posedge mclk);
    rd(8'h1c, 32'h20);
    wr(8'h04, 32'h0);
    pins(6'h30, 6'h00, 6'h00);
    wr(8'h10, 32'h05);
    `CHK("out", 6'h2f, spare_pin_out)
    wr(8'h14, 32'h0a);
    `CHK("out", 6'h25, spare_pin_out)
    wr(8'h18, 32'h0d);
    pins(6'h10, 6'h00, 6'h00);
    `CHK("out", 6'h05, spare_pin_out)
    wr(8'h18, 32'h0e);
    rd(8'h00, 32'h2f);
    rd(8'h08, 32'h05);
    rd(8'h18, 32'h0);
    wr(8'h18, 32'h24);
    pins(6'h10, 6'h00, 6'h10);
    rd(8'h04, 32'h200);
    rd(8'h0c, 32'h15);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    #1 pins(6'h3f, 6'h3f, 6'h00);
    rd(8'h00, 32'h0);
    results;
  end
endmodule
`default_nettype wire
